// [rtl/sarsq_cfg.svh]
/*
  Fixed figures of the successive-approximation sequencer.
  Assumes inclusion by bare name from the package and the top module.
*/
`ifndef SARSQ_CFG_SVH
`define SARSQ_CFG_SVH

// Word layout
`define SQ_BITS 14
`define SQ_MSB 13
`define SQ_LAST 4'hd
`define SQ_ARM_WORD 14'h1fff

// Timing in nanoseconds
`define SQ_CLK_NS 25
`define SQ_SER_NS 20
`define SQ_CONV_NS_HI 12000
`define SQ_CONV_NS_MED 25000
`define SQ_CMD_MIN_NS 200
`define SQ_CMD_MAX_NS 400

// Serial delay, least time rounded up
`define SQ_SER_CYC ((`SQ_SER_NS + `SQ_CLK_NS - 1) / `SQ_CLK_NS)

`endif

// [rtl/sarsq_pkg.sv]
/*
  Types shared by the sequencer.
  Assumes sarsq_cfg.svh on the include path.
*/
`default_nettype none
`include "sarsq_cfg.svh"

package sarsq_pkg;

    typedef enum logic [2:0] {
        SQ_IDLE = 3'h1,
        SQ_ARM = 3'h2,
        SQ_CONV = 3'h4
    } sarsq_state_e;

    typedef struct packed {
        logic bipolar;
        logic twos;
    } sarsq_code_s;

endpackage : sarsq_pkg

`default_nettype wire

// [rtl/sarsq_top.sv]
/*
  Conversion sequencer: arms on the convert command, steps one bit per
  rising bit-clock edge, drives parallel and serial results.
  Assumes bit_clk_in is clk_out looped back or an external bit clock
  slower than four system clocks; dac_below_in settles within a bit.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sarsq_cfg.svh"

module sarsq_top
    import sarsq_pkg::*;
#(
    parameter int CONV_NS = `SQ_CONV_NS_HI
) (
    // System clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Bit clock and comparator
    input wire logic bit_clk_in,
    input wire logic dac_below_in,
    // Host command and straps
    input wire logic convert_in,
    input wire logic short_n_in,
    input wire sarsq_code_s code_in,
    // Results
    output logic clk_out,
    output logic status_out,
    output logic status_n_out,
    output logic msb_n_out,
    output logic [`SQ_BITS-1:0] data_out,
    output logic serial_out
);

    // Longest bit period rounds down
    localparam int BIT_CYC = CONV_NS / (`SQ_BITS * `SQ_CLK_NS);
    localparam int HALF_CYC = (BIT_CYC / 2 > 0) ? BIT_CYC / 2 : 1;
    localparam int DIV_W = $clog2(HALF_CYC + 1);
    localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(HALF_CYC - 1);
    localparam logic [3:0] SER_LD = 4'(`SQ_SER_CYC);
    localparam logic [3:0] MSB_POS = 4'(`SQ_MSB);

    logic link_tog_r, link_tog_nxt;
    logic link_dec_r, link_dec_nxt;
    logic conv_m_r, conv_s_r, conv_d_r;
    logic tog_m_r, tog_s_r, tog_d_r;
    logic short_m_r, short_s_r;
    sarsq_code_s code_m_r, code_s_r;
    sarsq_state_e st_r, st_nxt;
    logic [`SQ_BITS-1:0] sar_r, sar_nxt;
    logic [`SQ_BITS-1:0] par_r, par_nxt;
    logic [3:0] idx_r, idx_nxt;
    logic [3:0] pos;
    logic [DIV_W-1:0] div_r, div_nxt;
    logic clk_r, clk_nxt;
    logic status_r, status_nxt;
    logic status_n_r, status_n_nxt;
    logic msb_n_r, msb_n_nxt;
    logic [3:0] ser_cnt_r, ser_cnt_nxt;
    logic ser_hold_r, ser_hold_nxt;
    logic serial_r, serial_nxt;
    logic conv_rise, conv_fall, take_edge, finish;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    // Link side: one toggle and one decision per rising bit-clock edge
    always_comb begin
        link_tog_nxt = ~link_tog_r;
        link_dec_nxt = dac_below_in;
    end

    always_ff @(posedge bit_clk_in or posedge rst_in) begin
        if (rst_in) begin
            link_tog_r <= 1'h0;
            link_dec_r <= 1'h0;
        end else begin
            link_tog_r <= link_tog_nxt;
            link_dec_r <= link_dec_nxt;
        end
    end

    // Command synchroniser
    // A pulse of the least width spans several system clocks
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            conv_m_r <= 1'h0;
            conv_s_r <= 1'h0;
            conv_d_r <= 1'h0;
            tog_m_r <= 1'h0;
            tog_s_r <= 1'h0;
            tog_d_r <= 1'h0;
            short_m_r <= 1'h1;
            short_s_r <= 1'h1;
            code_m_r <= '0;
            code_s_r <= '0;
        end else begin
            conv_m_r <= convert_in;
            conv_s_r <= conv_m_r;
            conv_d_r <= conv_s_r;
            tog_m_r <= link_tog_r;
            tog_s_r <= tog_m_r;
            tog_d_r <= tog_s_r;
            short_m_r <= short_n_in;
            short_s_r <= short_m_r;
            code_m_r <= code_in;
            code_s_r <= code_m_r;
        end
    end

    always_comb begin
        conv_rise = conv_s_r & ~conv_d_r;
        conv_fall = ~conv_s_r & conv_d_r;
        take_edge = (tog_s_r ^ tog_d_r) & (st_r == SQ_CONV);
        pos = MSB_POS - idx_r;
    end

    // Sequencer
    always_comb begin
        st_nxt = st_r;
        sar_nxt = sar_r;
        idx_nxt = idx_r;
        div_nxt = div_r;
        clk_nxt = clk_r;
        ser_cnt_nxt = ser_cnt_r;
        ser_hold_nxt = ser_hold_r;
        serial_nxt = serial_r;
        finish = 1'h0;
        if (conv_rise) begin
            st_nxt = SQ_ARM;
            sar_nxt = `SQ_ARM_WORD;
            idx_nxt = 4'h0;
            div_nxt = '0;
            clk_nxt = 1'h1;
        end else begin
            case (st_r)
                SQ_IDLE: begin
                end
                SQ_ARM: begin
                    if (conv_fall) begin
                        st_nxt = SQ_CONV;
                        clk_nxt = 1'h0;
                        div_nxt = '0;
                    end
                end
                SQ_CONV: begin
                    if (div_r == HALF_LAST) begin
                        div_nxt = '0;
                        clk_nxt = ~clk_r;
                    end else begin
                        div_nxt = div_r + 1'h1;
                    end
                    if (take_edge) begin
                        sar_nxt[pos] = link_dec_r;
                        ser_hold_nxt = link_dec_r;
                        ser_cnt_nxt = SER_LD;
                        if (idx_r == `SQ_LAST) begin
                            finish = 1'h1;
                        end else begin
                            sar_nxt[pos - 4'h1] = 1'h0;
                            idx_nxt = idx_r + 4'h1;
                        end
                    end else if (!short_s_r) begin
                        finish = 1'h1;
                    end
                end
                default: begin
                    st_nxt = SQ_IDLE;
                end
            endcase
        end
        if (finish) begin
            st_nxt = SQ_IDLE;
            clk_nxt = 1'h0;
            div_nxt = '0;
        end
        if (ser_cnt_r != 4'h0 && !take_edge) begin
            ser_cnt_nxt = ser_cnt_r - 4'h1;
            if (ser_cnt_r == 4'h1) begin
                serial_nxt = ser_hold_r;
            end
        end
    end

    // Result and status outputs
    always_comb begin
        par_nxt = par_r;
        msb_n_nxt = msb_n_r;
        status_nxt = (st_nxt != SQ_IDLE);
        status_n_nxt = (st_nxt == SQ_IDLE);
        if (conv_rise || st_r != SQ_IDLE) begin
            par_nxt = sar_nxt;
            par_nxt[`SQ_MSB] = sar_nxt[`SQ_MSB]
                ^ (code_s_r.bipolar & code_s_r.twos);
            msb_n_nxt = ~sar_nxt[`SQ_MSB];
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= SQ_IDLE;
            sar_r <= '0;
            par_r <= '0;
            idx_r <= 4'h0;
            div_r <= '0;
            clk_r <= 1'h0;
            status_r <= 1'h0;
            status_n_r <= 1'h1;
            msb_n_r <= 1'h1;
            ser_cnt_r <= 4'h0;
            ser_hold_r <= 1'h0;
            serial_r <= 1'h0;
        end else begin
            st_r <= st_nxt;
            sar_r <= sar_nxt;
            par_r <= par_nxt;
            idx_r <= idx_nxt;
            div_r <= div_nxt;
            clk_r <= clk_nxt;
            status_r <= status_nxt;
            status_n_r <= status_n_nxt;
            msb_n_r <= msb_n_nxt;
            ser_cnt_r <= ser_cnt_nxt;
            ser_hold_r <= ser_hold_nxt;
            serial_r <= serial_nxt;
        end
    end

    assign clk_out = clk_r;
    assign status_out = status_r;
    assign status_n_out = status_n_r;
    assign msb_n_out = msb_n_r;
    assign data_out = par_r;
    assign serial_out = serial_r;

    a_arm_outputs_set: assert property (
        conv_rise |=> status_r && clk_r && msb_n_r
            && sar_r == `SQ_ARM_WORD)
        else $error("Arm did not set trial word and outputs");

    a_hold_while_cmd: assert property (
        (st_r == SQ_ARM && conv_s_r && !conv_rise)
            |=> $stable(sar_r) && clk_r && st_r == SQ_ARM)
        else $error("Sequencer moved while command high");

    a_msb_decide: assert property (
        (take_edge && idx_r == 4'h0)
            |=> sar_r[`SQ_MSB] == $past(link_dec_r)
            && !sar_r[`SQ_MSB-1])
        else $error("MSB decision wrong");

    a_next_trial: assert property (
        (take_edge && idx_r < `SQ_LAST)
            |=> idx_r == $past(idx_r) + 4'h1
            && !sar_r[MSB_POS - idx_r])
        else $error("Next bit not placed on trial");

    a_end_low: assert property (
        $fell(status_r) |-> !clk_r && st_r == SQ_IDLE)
        else $error("Clock still high after conversion end");

    a_serial_delay: assert property (
        take_edge |-> ##2 serial_r == $past(link_dec_r, 2))
        else $error("Serial bit late or wrong");

    a_status_pair: assert property (
        status_n_r == !status_r && status_r == (st_r != SQ_IDLE))
        else $error("Status pair inconsistent");

    a_par_coding: assert property (
        (st_r != SQ_IDLE && $stable(code_s_r))
            |-> par_r[`SQ_MSB] == (sar_r[`SQ_MSB]
            ^ (code_s_r.bipolar & code_s_r.twos)))
        else $error("Parallel coding wrong");

    a_serial_raw: assert property (
        (take_edge && idx_r == 4'h0 && !conv_rise)
            |-> ##2 serial_r == sar_r[`SQ_MSB])
        else $error("Serial MSB is not raw code");

    a_full_length: assert property (
        (take_edge && idx_r == `SQ_LAST && !conv_rise)
            |=> st_r == SQ_IDLE && !status_r)
        else $error("Conversion did not end after last bit");

    a_bit_rate: assert property (
        (st_r == SQ_CONV && div_r == HALF_LAST && !conv_rise)
            |=> clk_r != $past(clk_r) || st_r == SQ_IDLE)
        else $error("Bit clock half period wrong");

    a_short_end: assert property (
        (st_r == SQ_CONV && !short_s_r && !take_edge && !conv_rise)
            |=> st_r == SQ_IDLE)
        else $error("Short cycle did not end conversion");

    a_hold_result: assert property (
        (st_r == SQ_IDLE && !conv_rise)
            |=> $stable(par_r) && $stable(msb_n_r))
        else $error("Result changed while idle");

endmodule : sarsq_top

`default_nettype wire

// [sim/sar_conversion_sequencer_bench.sv]
/*
  Self-checking bench for the conversion sequencer.
  Assumes sarsq_pkg compiled first and the far-side model alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module sar_conversion_sequencer_bench;
    import sarsq_pkg::*;
    logic clk = 1'b0;
    logic rst, convert, bit_clk, below, short_n, clk_o, status, status_n;
    logic msb_n, serial;
    logic [13:0] data, target, ser_word;
    sarsq_code_s code;
    int sc_n, n_dec, fails, n_tests, run, half;
    logic prev_c, prev_s;

    always #12.5 clk = ~clk;
    // Bit N+1 looped back for an N-bit short cycle
    assign short_n = (sc_n < 14) ? data[13 - sc_n] : 1'b1;

    sarsq_top dut (
        .clock_in(clk), .rst_in(rst), .bit_clk_in(bit_clk),
        .dac_below_in(below), .convert_in(convert), .short_n_in(short_n),
        .code_in(code), .clk_out(clk_o), .status_out(status),
        .status_n_out(status_n), .msb_n_out(msb_n), .data_out(data),
        .serial_out(serial)
    );
    sarsq_far_model far (
        .status_in(status), .convert_in(convert), .serial_in(serial),
        .target_in(target), .bit_clk_out(bit_clk), .dac_below_out(below),
        .ser_word_out(ser_word), .n_dec_out(n_dec)
    );

    // Low run of clk_out while busy, sampled off the launching edge
    always @(negedge clk) begin
        if (clk_o !== prev_c) begin
            if (clk_o && prev_s) begin
                half <= run;
            end
            run <= 1;
        end else begin
            run <= run + 1;
        end
        prev_c <= clk_o;
        prev_s <= status;
    end

    task automatic check(input string name, input logic [13:0] seen,
                         input logic [13:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    task automatic convert_once(input logic [13:0] tgt, input sarsq_code_s cd,
                                input int n);
        logic [13:0] arm;
        @(negedge clk);
        target = tgt;
        code = cd;
        sc_n = n;
        convert = 1'b1;
        repeat (6) @(negedge clk);
        // Bipolar two's complement shows the trial MSB inverted
        arm = {cd == 2'b11, 13'h1fff};
        check("arm data", data, arm);
        check("arm pins", {clk_o, msb_n}, 2'b11);
        check("arm status", {status, status_n}, 2'b10);
        repeat (3) @(negedge clk);
        check("held pins", {clk_o, status}, 2'b11);
        check("held data", data, arm);
        @(negedge clk);
        convert = 1'b0;
        // Next command only after status falls
        for (int i = 0; status !== 1'b0; i++) begin
            if (i > 400) begin
                fails++;
                finish_test();
            end
            @(negedge clk);
        end
        // Last serial bit, and the count of a full-length run, land after status falls
        repeat (4) @(negedge clk);
    endtask : convert_once

    task automatic t_codes();
        sarsq_code_s cds[4] = '{2'b00, 2'b01, 2'b10, 2'b11};
        logic [13:0] tg[4] = '{14'h2a5c, 14'h3fff, 14'h0001, 14'h2000};
        logic [13:0] exp;
        for (int i = 0; i < 4; i++) begin
            convert_once(tg[i], cds[i], 14);
            exp = tg[i] ^ {cds[i] == 2'b11, 13'h0};
            check("parallel", data, exp);
            check("serial", ser_word, tg[i]);
            check("msb_n", msb_n, !tg[i][13]);
            check("end pins", {status, status_n, clk_o}, 3'b010);
            check("decisions", 14'(n_dec), 14'he);
            check("half period", 14'(half), 14'h11);
            code = ~cds[i];
            repeat (12) @(negedge clk);
            check("held result", data, exp);
        end
    endtask : t_codes

    task automatic t_short();
        int ns[2] = '{1, 13};
        logic [13:0] top;
        for (int i = 0; i < 2; i++) begin
            convert_once(14'h2a5c, 2'b00, ns[i]);
            top = ~(14'h3fff >> ns[i]);
            check("short data", data,
                  (14'h2a5c & top) | (~top & ~(14'h2000 >> ns[i])));
            check("short count", 14'(n_dec), 14'(ns[i]));
            check("short end", {status, clk_o}, 2'b00);
        end
        sc_n = 14;
    endtask : t_short

    initial begin
        rst = 1'b1;
        convert = 1'b0;
        code = 2'b00;
        target = 14'h0;
        sc_n = 14;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        check("reset pins", {clk_o, status, status_n, msb_n, serial},
              5'h6);
        check("reset data", data, 14'h0);
        t_codes();
        t_short();
        finish_test();
    end
endmodule : sar_conversion_sequencer_bench
`default_nettype wire

// [sim/sarsq_far_model.sv]
/*
  Far-side model: comparator and external bit clock for the sequencer.
  Assumes the bench gives the analog input as a code on target_in.
*/
`timescale 1ns/1ps
`default_nettype none
module sarsq_far_model (
    // Watched device pins and target code
    input wire logic status_in,
    input wire logic convert_in,
    input wire logic serial_in,
    input wire logic [13:0] target_in,
    // Driven pins
    output logic bit_clk_out,
    output logic dac_below_out,
    // Captured results
    output logic [13:0] ser_word_out,
    output int n_dec_out
);
    logic [13:0] acc;
    logic [13:0] trial;
    initial begin
        bit_clk_out = 1'b0;
        dac_below_out = 1'b0;
        ser_word_out = 14'h0;
        n_dec_out = 0;
        forever begin
            @(negedge convert_in);
            acc = 14'h0;
            n_dec_out = 0;
            #200;
            // Clock stands still outside a frame
            while (status_in && n_dec_out < 14) begin
                trial = acc | (14'h2000 >> n_dec_out);
                // Inclusive compare, so the result equals the target
                dac_below_out = (trial <= target_in);
                #10;
                bit_clk_out = 1'b1;
                #80;
                bit_clk_out = 1'b0;
                // Decision held well past the device's read point
                #40;
                acc = dac_below_out ? trial : acc;
                n_dec_out++;
                #30;
                ser_word_out = {ser_word_out[12:0], serial_in};
            end
        end
    end
endmodule : sarsq_far_model
`default_nettype wire
